// *** hw/pcg_pkg.sv ***
// Operation
// [R1] Four pads in two independently controlled pairs
// [R2] Input storage selectable latch or flip-flop
// [R3] Input storage demultiplexes shared address/data
// [R4] Output flop takes two-signal per-pad logic
// [R5] Registered address muxed with data output
// [R6] Output data inversion selectable
// [R7] Three-state sense high, low, or always
// [R8] Three-state control registered or direct
// [R9] Shift registers divide input, multiply output
// [R10] DDR captures and launches both edges
// [R11] Pad is input, output or bidirectional
// [R12] Fast direct input path to decoder
// [R13] Clock source fast, secondary or edge
// [R14] Rate factor two or four, shared clock
// [R15] Latch holds falling edge, both ready rising
// [R16] Selections are static configuration
package pcg_pkg;
   localparam logic [4:0] PCG_OFS_PAD    = 5'h00;  // Per-pad config, one byte each
   localparam logic [4:0] PCG_OFS_PAIR   = 5'h04;  // Per-pair controls, one byte each
   localparam logic [4:0] PCG_OFS_SRB    = 5'h08;  // Rate shift block config
   localparam logic [4:0] PCG_OFS_STAT   = 5'h0C;  // Read-only state
   localparam int         PCG_F_DIR      = 0;      // 2 bits: 0 in, 1 out, 2 bidir
   localparam int         PCG_F_LAT      = 2;      // 1 latch, 0 flip-flop
   localparam int         PCG_F_INV      = 3;      // Output inversion
   localparam int         PCG_F_TSM      = 4;      // 2 bits: 0 high, 1 low, 2 always
   localparam int         PCG_F_TSR      = 6;      // Registered three-state
   localparam int         PCG_F_FUN      = 7;      // 0 mux a/b, 1 xor a/b
   localparam int         PCG_P_CKS      = 0;      // 2 bits clock source
   localparam int         PCG_P_CEN      = 2;      // Clock enable active low
   localparam int         PCG_P_LSE      = 3;      // Local set/reset used
   localparam int         PCG_P_GSE      = 4;      // Global set/reset used
   localparam int         PCG_S_RAT      = 0;      // 2 bits: 0 off, 1 x2, 2 x4
   localparam int         PCG_S_DDR      = 2;      // Double data rate
   localparam int         PCG_S_SER      = 3;      // Serializer owns pad 3
   localparam logic [1:0] PCG_DIR_IN     = 2'h0;
   localparam logic [1:0] PCG_DIR_OUT    = 2'h1;
   localparam logic [1:0] PCG_TS_HIGH    = 2'h0;
   localparam logic [1:0] PCG_TS_LOW     = 2'h1;
   localparam logic [1:0] PCG_RAT_X2     = 2'h1;
   localparam logic [1:0] PCG_RAT_X4     = 2'h2;
   localparam logic [31:0] PCG_RST_PAD  = 32'h00000000;
   localparam logic [15:0] PCG_RST_PAIR = 16'h0000;
   localparam logic [3:0]  PCG_RST_SRB  = 4'h0;
   localparam logic [1:0]  PCG_RESP_OK  = 2'h0;
   localparam logic [1:0]  PCG_RESP_ERR = 2'h2;
endpackage : pcg_pkg

// *** hw/pcg_group.sv ***
`timescale 1ns/100ps
// Word FIFO between rate shift block and core
module pcg_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // Flip-flop storage
   logic [AW-1:0]    wp;           // Write index
   logic [AW-1:0]    rp;           // Read index
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rp];
   // Pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else begin
         if (push) wp <= wp + 1'b1;
         if (pop) rp <= rp + 1'b1;
         level <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Storage has no reset; only valid words are read
   always_ff @(posedge clk) begin
      if (push) mem[wp] <= in_data;
   end
   fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n) level <= (AW+1)'(DEPTH))
      else $error("fifo level past depth");
endmodule : pcg_fifo

// Four-pad I/O group with AXI4-Lite configuration
module pcg_group (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic [3:0]           pad_in,
   output logic      [3:0]           pad_out,
   output logic      [3:0]           pad_oe_n,
   input  wire logic [2:0]           clk_tick,
   input  wire logic [1:0]           pair_ce,
   input  wire logic [1:0]           pair_lsr,
   input  wire logic                 gsr_n,
   input  wire logic [3:0]           core_a,
   input  wire logic [3:0]           core_b,
   input  wire logic [3:0]           core_sel,
   input  wire logic [3:0]           core_ts,
   input  wire logic [3:0]           core_fall,
   output logic      [3:0]           direct_input_out,
   output logic      [3:0]           latched_input_out,
   output logic      [3:0]           rise_input_out,
   output logic      [3:0]           rx_word,
   output logic                      rx_valid,
   input  wire logic                 rx_ready,
   input  wire logic [3:0]           tx_word,
   input  wire logic                 tx_valid,
   output logic                      tx_ready,
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic      [1:0]           s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [31:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic      [31:0]          s_axi_rdata,
   output logic      [1:0]           s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);
   import pcg_pkg::*;

   // Pick one of fast, secondary, edge ticks
   function automatic logic sel_tick(input logic [1:0] src, input logic [2:0] t);
      sel_tick = (src < 2'h3) ? t[src] : 1'b0;  // [R13]
   endfunction : sel_tick

   logic [1:0]  rsync;         // Reset release pipeline
   logic        rst_n;         // Internal reset copy
   logic [31:0] cfg_pad;       // Four pad bytes
   logic [15:0] cfg_pair;      // Two pair bytes
   logic [3:0]  cfg_srb;       // Rate shift config
   logic        aw_held;       // Write address captured
   logic        w_held;        // Write data captured
   logic [4:0]  aw_q;          // Held write offset
   logic [31:0] w_q;           // Held write data
   logic [3:0]  ws_q;          // Held strobes
   logic [3:0]  in_pos;        // Rising edge capture
   logic [3:0]  in_neg;        // Falling edge latch
   logic [3:0]  out_q;         // Output flop
   logic [3:0]  ddr_p;         // DDR rising launch
   logic [3:0]  ddr_n;         // DDR falling launch
   logic [3:0]  ts_q;          // Registered three-state
   logic [3:0]  des_sr;        // Deserializer shift
   logic [1:0]  des_cnt;       // Bits collected
   logic        des_push;      // Word waiting for FIFO
   logic [3:0]  des_word;      // Word to FIFO
   logic [3:0]  ser_sr;        // Serializer shift
   logic [1:0]  ser_cnt;       // Bits left
   logic [5:0]  fifo_lvl;      // FIFO fill
   logic        fifo_in_ready; // FIFO can take a word

   // Two-flop reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rsync <= 2'h0;
      else rsync <= {rsync[0], 1'b1};
   end
   assign rst_n = rsync[1];

   // Per-pad decoded fields and pair controls
   wire [3:0] f_lat;
   wire [3:0] f_inv;
   wire [3:0] f_tsr;
   wire [3:0] f_fun;
   wire [3:0] pad_en;          // Capture/launch allowed this cycle
   wire [3:0] pad_clr;         // Local or global clear
   wire [3:0] next_out;        // Two-signal output logic
   wire [3:0] ts_eff;          // Three-state source
   wire [3:0] drive;           // Pad driven
   wire       ddr_on  = cfg_srb[PCG_S_DDR];
   wire [1:0] ratio   = cfg_srb[PCG_S_RAT +: 2];
   wire       des_on  = (ratio == PCG_RAT_X2) || (ratio == PCG_RAT_X4);  // [R14]
   wire [1:0] des_last = (ratio == PCG_RAT_X4) ? 2'h3 : 2'h1;            // [R14]
   wire       ser_on  = cfg_srb[PCG_S_SER] && des_on;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gp
         localparam int P = g / 2;  // Pair index [R1]
         wire [7:0] pc = cfg_pad[8*g +: 8];
         wire [7:0] qc = cfg_pair[8*P +: 8];
         wire [1:0] dir = pc[PCG_F_DIR +: 2];
         wire [1:0] tsm = pc[PCG_F_TSM +: 2];
         wire       ce  = pair_ce[P] ^ qc[PCG_P_CEN];
         assign f_lat[g]   = pc[PCG_F_LAT];
         assign f_inv[g]   = pc[PCG_F_INV];
         assign f_tsr[g]   = pc[PCG_F_TSR];
         assign f_fun[g]   = pc[PCG_F_FUN];
         assign pad_en[g]  = ce && sel_tick(qc[PCG_P_CKS +: 2], clk_tick);   // [R1] [R13]
         assign pad_clr[g] = (qc[PCG_P_LSE] && pair_lsr[P]) || (qc[PCG_P_GSE] && !gsr_n);  // [R1]
         // Mux or combine the two core signals
         assign next_out[g] = f_fun[g] ? (core_a[g] ^ core_b[g])
                                       : (core_sel[g] ? core_b[g] : core_a[g]);  // [R4] [R5]
         assign ts_eff[g] = f_tsr[g] ? ts_q[g] : core_ts[g];                     // [R8]
         // Direction, then three-state sense
         assign drive[g] = (dir == PCG_DIR_IN)  ? 1'b0 :
                           (dir == PCG_DIR_OUT) ? 1'b1 :
                           (tsm == PCG_TS_HIGH) ? !ts_eff[g] :
                           (tsm == PCG_TS_LOW)  ? ts_eff[g] : 1'b1;              // [R7] [R11]
      end
   endgenerate

   // Fast pad-to-decoder path, no storage
   assign direct_input_out = pad_in;  // [R12] [R15]

   // Rising edge input capture, flip-flop mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) in_pos <= 4'h0;
      else in_pos <= (in_pos & ~pad_en & ~pad_clr) | (pad_in & pad_en & ~pad_clr);  // [R2] [R10]
   end

   // Falling edge hold, latch mode or DDR second half
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) in_neg <= 4'h0;
      else in_neg <= (in_neg & ~pad_en & ~pad_clr) | (pad_in & pad_en & ~pad_clr);  // [R3] [R10] [R15]
   end
   // Latch-held value beside the direct value gives the demultiplexed pair
   assign latched_input_out = (f_lat | {4{ddr_on}}) & in_neg | ~(f_lat | {4{ddr_on}}) & in_pos;  // [R2] [R3]
   assign rise_input_out    = in_pos;  // [R10]

   // Output flop and registered three-state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 4'h0;
         ts_q  <= 4'h0;
      end else begin
         out_q <= (out_q & ~pad_en & ~pad_clr) | (next_out & pad_en & ~pad_clr);  // [R4] [R5]
         ts_q  <= (ts_q & ~pad_en) | (core_ts & pad_en);                          // [R8]
      end
   end

   // DDR launch: xor pair avoids muxing on the clock itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ddr_p <= 4'h0;
      else ddr_p <= next_out ^ ddr_n;  // [R10]
   end
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) ddr_n <= 4'h0;
      else ddr_n <= core_fall ^ ddr_p;  // [R10]
   end

   // Pad drive: serializer owns pad 3 when on
   wire [3:0] pad_raw = ddr_on ? (ddr_p ^ ddr_n) : out_q;
   wire [3:0] pad_sel = {ser_on ? ser_sr[0] : pad_raw[3], pad_raw[2:0]};  // [R9]
   assign pad_out  = pad_sel ^ f_inv;  // [R6]
   assign pad_oe_n = ~drive;           // [R11]

   // Deserializer on pad 0; stalls while its word waits
   assign des_word = des_sr;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         des_sr   <= 4'h0;
         des_cnt  <= 2'h0;
         des_push <= 1'b0;
      end else if (des_push) begin
         if (fifo_in_ready) des_push <= 1'b0;  // Back-pressure holds shifting
      end else if (des_on) begin
         des_sr  <= {pad_in[0], des_sr[3:1]};  // [R9] [R14]
         des_cnt <= (des_cnt == des_last) ? 2'h0 : des_cnt + 2'h1;
         if (des_cnt == des_last) des_push <= 1'b1;
      end
   end

   pcg_fifo #(.WIDTH(4), .DEPTH(32)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (des_word),
      .in_valid  (des_push),
      .in_ready  (fifo_in_ready),
      .out_data  (rx_word),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .level     (fifo_lvl)
   );

   // Serializer to pad 3, same clock as the deserializer
   assign tx_ready = ser_on && (ser_cnt == 2'h0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_sr  <= 4'h0;
         ser_cnt <= 2'h0;
      end else if (tx_valid && tx_ready) begin
         ser_sr  <= tx_word;   // [R9] [R14]
         ser_cnt <= des_last;
      end else if (ser_cnt != 2'h0) begin
         ser_sr  <= {1'b0, ser_sr[3:1]};
         ser_cnt <= ser_cnt - 2'h1;
      end
   end

   // AXI write: address and data in either order
   wire       wr_go  = aw_held && w_held && !s_axi_bvalid;
   wire       wr_map = (aw_q == PCG_OFS_PAD) || (aw_q == PCG_OFS_PAIR) || (aw_q == PCG_OFS_SRB);
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
   endfunction : merge
   wire [31:0] pair_mrg = merge({16'h0000, cfg_pair}, w_q, ws_q);  // Pair bytes after strobes
   wire [31:0] srb_mrg  = merge({28'h0, cfg_srb}, w_q, ws_q);       // Rate config after strobes

   // Capture channels, commit, respond
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= 5'h00;
         w_q     <= 32'h00000000;
         ws_q    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PCG_RESP_OK;
         cfg_pad  <= PCG_RST_PAD;
         cfg_pair <= PCG_RST_PAIR;
         cfg_srb  <= PCG_RST_SRB;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_q    <= {s_axi_awaddr[4:2], 2'h0};
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_q    <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end
         if (wr_go) begin
            // Static settings: software writes only while idle [R16]
            if (aw_q == PCG_OFS_PAD) cfg_pad <= merge(cfg_pad, w_q, ws_q);
            if (aw_q == PCG_OFS_PAIR) cfg_pair <= pair_mrg[15:0];
            if (aw_q == PCG_OFS_SRB) cfg_srb <= srb_mrg[3:0];
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? PCG_RESP_OK : PCG_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI read: one outstanding, registered data
   wire [4:0]  ar_ofs = {s_axi_araddr[4:2], 2'h0};
   wire [31:0] rd_mux = (ar_ofs == PCG_OFS_PAD)  ? cfg_pad :
                        (ar_ofs == PCG_OFS_PAIR) ? {16'h0000, cfg_pair} :
                        (ar_ofs == PCG_OFS_SRB)  ? {28'h0000000, cfg_srb} :
                        {18'h00000, fifo_lvl, in_neg, in_pos};
   wire        rd_map = (ar_ofs <= PCG_OFS_STAT);
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= PCG_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_map ? rd_mux : 32'h00000000;
         s_axi_rresp  <= rd_map ? PCG_RESP_OK : PCG_RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Checks on the pad, shift and AXI write logic
   in_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg_pad[PCG_F_DIR +: 2] == PCG_DIR_IN) |-> pad_oe_n[0]) else $error("input pad driven");  // [R11]
   ts_always_a: assert property (@(posedge clk) disable iff (!rst_n)  // [R7]
      (cfg_pad[9:8] == 2'h2 && cfg_pad[13:12] == 2'h2) |-> !pad_oe_n[1]) else $error("ts always off");
   ts_direct_a: assert property (@(posedge clk) disable iff (!rst_n)  // [R7] [R8]
      (cfg_pad[25:24] == 2'h2 && cfg_pad[29:28] == PCG_TS_LOW && !cfg_pad[30])
      |-> (pad_oe_n[3] == !core_ts[3])) else $error("ts direct sense");
   out_inv_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!ddr_on && !ser_on) |-> (pad_out == (out_q ^ f_inv))) else $error("output inversion");  // [R6]
   ff_capt_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pad_en[0] && !pad_clr[0]) |=> (in_pos[0] == $past(pad_in[0]))) else $error("input capture");  // [R2]
   out_hold_a: assert property (@(posedge clk) disable iff (!rst_n)  // [R1] [R4]
      (!pad_en[3] && !pad_clr[3]) |=> $stable(out_q[3])) else $error("output held off ce");
   out_mux_a: assert property (@(posedge clk) disable iff (!rst_n)  // [R5]
      (pad_en[2] && !pad_clr[2] && !f_fun[2])
      |=> (out_q[2] == ($past(core_sel[2]) ? $past(core_b[2]) : $past(core_a[2]))))
      else $error("output mux");
   des_stall_a: assert property (@(posedge clk) disable iff (!rst_n)
      (des_push && !fifo_in_ready) |=> (des_push && $stable(des_sr))) else $error("shift not stalled");  // [R9]
   ser_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      (tx_valid && tx_ready && ratio == PCG_RAT_X4) |=> (ser_cnt == 2'h3) ##1 (ser_cnt == 2'h2))
      else $error("serializer count");  // [R14]
   wr_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_go |=> s_axi_bvalid) else $error("missing write response");
endmodule : pcg_group

// *** sim/pcg_pad_model.sv ***
`timescale 1ns/100ps
// Far side of the pads: an external source that can change every clock half
module pcg_pad_model (
   input  wire logic       clk,
   input  wire logic [3:0] drv_rise,  // Level shown in the high half
   input  wire logic [3:0] drv_fall,  // Level shown in the low half
   input  wire logic [3:0] pad_out,   // Cell output data
   input  wire logic [3:0] pad_oe_n,  // Low while the cell drives
   output logic      [3:0] pad_in     // Resolved pad level
);
   logic [3:0] far_lvl;  // External driver level, one value per half cycle
   // Address in the high half, data in the low half, as a shared bus does
   always @(clk) begin
      far_lvl <= clk ? drv_rise : drv_fall;
   end
   // A driving cell wins; otherwise the far side sets the pad
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & far_lvl);
endmodule : pcg_pad_model

// *** sim/programmable_io_cell_logic_tb.sv ***
`timescale 1ns/100ps
module programmable_io_cell_logic_tb;
   import pcg_pkg::*;
   logic clk, rstn, gsr_n, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [3:0] pad_in, pad_out, pad_oe_n, core_a, core_b, core_sel, core_ts, core_fall, rx_word, tx_word;
   logic [3:0] direct_input_out, latched_input_out, rise_input_out, drv_rise, drv_fall, s_axi_wstrb, ts_prev;
   logic [2:0] clk_tick;
   logic [1:0] pair_ce, pair_lsr, s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [15:0] vec [4] = '{16'h5306, 16'hA3C9, 16'hF0F0, 16'h0FAF};  // a, b, sel, ts nibbles
   int errors, cmp_count, cyc, cnt;
   pcg_group DUT (.*);
   pcg_pad_model FAR (.clk(clk), .drv_rise(drv_rise), .drv_fall(drv_fall), .pad_out(pad_out),
                      .pad_oe_n(pad_oe_n), .pad_in(pad_in));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         summarize();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task summarize();
      $display("checks %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // Write one word; address and data released each when taken
   task automatic axw(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] br;
      int n;
      n = 0;
      b = 1'h0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b && n < 40) begin
         @(negedge clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         n++;
      end
      s_axi_bready <= 1'h0;
      chk(br, er);
   endtask : axw
   // Read one word; rready held until rvalid is seen
   task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rr);
      logic ar, rv;
      int n;
      n = 0;
      rv = 1'h0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!rv && n < 40) begin
         @(negedge clk);
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         v = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'h0;
         n++;
      end
      s_axi_rready <= 1'h0;
      chk(rv, 1'h1);
   endtask : axr
   // Expected pad data: xor or mux of the two signals, then inversion
   function automatic logic [3:0] oexp(input logic [31:0] c, input logic [3:0] a, b, s);
      logic [3:0] o;
      for (int i = 0; i < 4; i++) o[i] = (c[8*i+7] ? a[i] ^ b[i] : (s[i] ? b[i] : a[i])) ^ c[8*i+3];
      return o;
   endfunction : oexp
   initial begin
      rstn = 1'h0; gsr_n = 1'h1; clk_tick = 3'h7; pair_ce = 2'h3; pair_lsr = 2'h0;
      {core_a, core_b, core_sel, core_ts, core_fall, drv_rise, drv_fall, tx_word} = 32'h0;
      {rx_ready, tx_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      // Reset values, unmapped read and write
      axr(PCG_OFS_PAD, d, r); chk(d, PCG_RST_PAD); chk(r, PCG_RESP_OK);
      axr(PCG_OFS_PAIR, d, r); chk(d, {16'h0, PCG_RST_PAIR});
      axr(PCG_OFS_SRB, d, r); chk(d, {28'h0, PCG_RST_SRB});
      axr(32'h10, d, r); chk(d, 32'h0); chk(r, PCG_RESP_ERR);
      axw(32'h14, 32'hFFFFFFFF, PCG_RESP_ERR);
      chk(pad_oe_n, 4'hF);
      $display("test registers done");
      // Output path: mux, xor, invert, three-state senses and registering
      axw(PCG_OFS_PAD, 32'h1242AA21, PCG_RESP_OK);
      axw(PCG_OFS_PAIR, 32'h0808, PCG_RESP_OK);
      axr(PCG_OFS_PAD, d, r); chk(d, 32'h1242AA21);
      ts_prev = 4'h0;
      foreach (vec[k]) begin
         @(posedge clk);
         {core_a, core_b, core_sel, core_ts} <= vec[k];
         @(negedge clk);
         chk(pad_oe_n, {~vec[k][3], ts_prev[2], 2'h0});
         @(negedge clk);
         chk(pad_out, oexp(32'h1242AA21, vec[k][15:12], vec[k][11:8], vec[k][7:4]));
         chk(pad_oe_n[2], vec[k][2]);
         ts_prev = vec[k][3:0];
      end
      $display("test output done");
      // Input capture and demultiplexing: pad 0 latch, others flip-flop
      axw(PCG_OFS_PAD, 32'h04, PCG_RESP_OK);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         drv_rise <= k ? 4'h3 : 4'hA;
         drv_fall <= k ? 4'hC : 4'h5;
         repeat (2) @(posedge clk);
         @(negedge clk);
         #40;
         chk(direct_input_out, k ? 4'hC : 4'h5);
         chk(latched_input_out, k ? 4'hD : 4'h4);
         chk(rise_input_out, k ? 4'hC : 4'h5);
      end
      // Pair 1 on a stopped secondary clock holds; pair 0 clears locally
      axw(PCG_OFS_PAIR, 32'h1908, PCG_RESP_OK);
      @(posedge clk);
      clk_tick <= 3'h5;
      drv_fall <= 4'h3;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(rise_input_out, 4'hF);
      @(posedge clk);
      pair_lsr <= 2'h1;
      @(posedge clk);
      pair_lsr <= 2'h0;
      @(negedge clk);
      chk(rise_input_out, 4'hC);
      // Pair 1 global clear, pair 0 clock enable off while its pads go low
      @(posedge clk);
      clk_tick <= 3'h7;
      drv_fall <= 4'h0;
      gsr_n <= 1'h0;
      pair_ce <= 2'h2;
      @(posedge clk);
      gsr_n <= 1'h1;
      pair_ce <= 2'h3;
      @(negedge clk);
      chk(rise_input_out, 4'h3);
      $display("test input done");
      // Double data rate launch on pad 1
      axw(PCG_OFS_PAD, 32'h2100, PCG_RESP_OK);
      axw(PCG_OFS_SRB, 32'h4, PCG_RESP_OK);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         core_a <= k ? 4'h0 : 4'hF;
         core_sel <= 4'h0;
         core_fall <= k ? 4'hF : 4'h0;
         repeat (2) @(posedge clk);
         #10 chk(pad_out[1], k ? 1'h0 : 1'h1);
         @(negedge clk);
         #10 chk(pad_out[1], k ? 1'h1 : 1'h0);
      end
      $display("test ddr done");
      // Rate x4: fill the buffer with core stalled, send one word, drain
      axw(PCG_OFS_PAD, 32'h21000000, PCG_RESP_OK);
      @(posedge clk);
      {drv_rise, drv_fall} <= 8'h11;
      axw(PCG_OFS_SRB, 32'hA, PCG_RESP_OK);
      cnt = 0;
      do begin
         axr(PCG_OFS_STAT, d, r);
         cnt++;
      end while (d[13:8] != 6'h20 && cnt < 90);
      chk(d[13:8], 6'h20);
      chk(rx_valid, 1'h1);
      @(posedge clk);
      tx_word <= 4'hB;
      tx_valid <= 1'h1;
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (tx_ready !== 1'h1 && cnt < 20);
      @(posedge clk);
      tx_valid <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         chk(pad_out[3], tx_word[i]);
      end
      axw(PCG_OFS_SRB, 32'h0, PCG_RESP_OK);
      @(posedge clk);
      rx_ready <= 1'h1;
      cnt = 0;
      @(negedge clk);
      while (rx_valid === 1'h1 && cnt < 40) begin
         chk(rx_word, 4'hF);
         cnt++;
         @(negedge clk);
      end
      chk(cnt >= 32, 1'h1);
      $display("test stream done");
      summarize();
   end
endmodule : programmable_io_cell_logic_tb
